// >>> include/csr_consts.svh
// Constants of the core special-register block: offsets, flag bits, reset values.
// Included by bare name from the design modules.
`ifndef CSR_CONSTS_SVH
`define CSR_CONSTS_SVH

// ****************************************
// Special register offsets within a sector
// ****************************************
`define CSR_ADR_PORT0 8'h00
`define CSR_ADR_PTR0 8'h01
`define CSR_ADR_PORT1 8'h02
`define CSR_ADR_PTR1L 8'h03
`define CSR_ADR_PTR1S 8'h04
`define CSR_ADR_PCLOW 8'h06
`define CSR_ADR_TBLO 8'h07
`define CSR_ADR_TBDH 8'h08
`define CSR_ADR_TBHI 8'h09
`define CSR_ADR_FLAGS 8'h0a
`define CSR_ADR_PORT2 8'h0c
`define CSR_ADR_PTR2L 8'h0d
`define CSR_ADR_PTR2S 8'h0e

// ****************************************
// Flag register bit positions
// ****************************************
`define CSR_BIT_C 0
`define CSR_BIT_HC 1
`define CSR_BIT_Z 2
`define CSR_BIT_OV 3
`define CSR_BIT_SLEEP 4
`define CSR_BIT_WDOG 5
`define CSR_BIT_CHAIN 6
`define CSR_BIT_SIGN 7
`define CSR_FLAGS_WR_TOP 3

// ****************************************
// Reset and fixed values
// ****************************************
`define CSR_BYTE_RST 8'h00
`define CSR_PORT_READ 8'h00
`define CSR_SECTOR_BYTES 256

`endif

// >>> include/csr_pkg.sv
// Types shared by the special-register block and its flag unit.
// Assumes csr_consts.svh is on the include path.
package csr_pkg;
  // Class of the instruction whose flags are being posted
  typedef enum logic [2:0] {
    csr_alu_none = 3'h0,
    csr_alu_add = 3'h1,
    csr_alu_sub = 3'h2,
    csr_alu_sbc = 3'h3,
    csr_alu_logic = 3'h4,
    csr_alu_rotate = 3'h5
  } csr_alu_kind_e;

  // Gray coded: idle is one bit away from each other state
  typedef enum logic [1:0] {
    csr_seq_idle = 2'b00,
    csr_seq_fetch = 2'b01,
    csr_seq_dummy = 2'b10
  } csr_seq_e;

  typedef logic [7:0] csr_byte_t;
endpackage

// >>> hdl/csr_flag_unit.sv
// Arithmetic and system flag register of the core.
// Assumes ALU flag inputs and system events are on ref_clk, one-cycle pulses.
`timescale 1ns/1ps
`include "csr_consts.svh"
module csr_flag_unit (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // ALU results
  input wire logic alu_upd,
  input wire csr_pkg::csr_alu_kind_e alu_kind,
  input wire csr_pkg::csr_byte_t alu_result,
  input wire logic alu_cout,
  input wire logic alu_cmsb,
  input wire logic alu_hc,
  input wire logic rot_carry,
  // Software write
  input wire logic sw_we,
  input wire csr_pkg::csr_byte_t sw_data,
  // System events
  input wire logic wdt_expire,
  input wire logic kick_op,
  input wire logic halt_op,
  // Flag view
  output csr_pkg::csr_byte_t flags
);
  import csr_pkg::*;

  logic carry;
  logic nibble_carry_flag;
  logic zero;
  logic signed_wrap_flag;
  logic sleep_entry_flag;
  logic watchdog_expired_flag;
  logic chained_null_flag;
  logic sign_xor_flag;
  logic next_ov;
  logic next_z;

  assign next_ov = alu_cmsb ^ alu_cout;
  assign next_z = (alu_result == `CSR_BYTE_RST);

  // ****************************************
  // Arithmetic flags
  // ****************************************
  // An ALU update in the same cycle drops the whole software write, even for flags it leaves alone
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      carry <= 1'b0;
      nibble_carry_flag <= 1'b0;
      zero <= 1'b0;
      signed_wrap_flag <= 1'b0;
      chained_null_flag <= 1'b0;
      sign_xor_flag <= 1'b0;
    end else if (alu_upd) begin
      case (alu_kind)
        csr_alu_add, csr_alu_sub, csr_alu_sbc: begin
          // RL12 carry and no-borrow
          carry <= alu_cout;
          // RL13 low nibble carry
          nibble_carry_flag <= alu_hc;
          // RL14 zero result
          zero <= next_z;
          // RL15 carry mismatch at top
          signed_wrap_flag <= next_ov;
          // RL16 overflow xor msb
          sign_xor_flag <= next_ov ^ alu_result[$left(alu_result)];
          // RL17 chained zero update
          if (alu_kind == csr_alu_sub) begin
            chained_null_flag <= next_z;
          end else if (alu_kind == csr_alu_sbc) begin
            chained_null_flag <= chained_null_flag & next_z;
          end
        end
        csr_alu_logic: begin
          // RL14 logical zero
          zero <= next_z;
        end
        csr_alu_rotate: begin
          // RL12 rotate through carry
          carry <= rot_carry;
        end
        default: begin
        end
      endcase
    end else if (sw_we) begin
      carry <= sw_data[`CSR_BIT_C];
      nibble_carry_flag <= sw_data[`CSR_BIT_HC];
      zero <= sw_data[`CSR_BIT_Z];
      signed_wrap_flag <= sw_data[`CSR_BIT_OV];
    end
  end

  // ****************************************
  // System flags
  // ****************************************
  // RL9 writes never reach these
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      watchdog_expired_flag <= 1'b0;
      sleep_entry_flag <= 1'b0;
    end else begin
      // RL10 timeout set wins over clear
      if (wdt_expire) begin
        watchdog_expired_flag <= 1'b1;
      end else if (kick_op || halt_op) begin
        watchdog_expired_flag <= 1'b0;
      end
      // RL11 halt sets, kick clears
      if (halt_op) begin
        sleep_entry_flag <= 1'b1;
      end else if (kick_op) begin
        sleep_entry_flag <= 1'b0;
      end
    end
  end

  assign flags = {sign_xor_flag, chained_null_flag, watchdog_expired_flag, sleep_entry_flag,
                  signed_wrap_flag, zero, nibble_carry_flag, carry};
endmodule

// >>> hdl/csr_core.sv
// Core special-register block: indirect ports, memory pointers, extended
// addressing, program-counter-low jumps, table reads and the flag register.
// Assumes one instruction stream on ref_clk issuing at most one data access a cycle,
// and a program memory whose word is valid in the cycle prog_req is high.
//
// Overview of operation
// RL1: Accesses to an indirect port act on the location its pointer holds.
// RL2: Port 0 reaches sector 0 only; ports 1 and 2 take sector from pointer.
// RL3: Port locations hold nothing: reading gives 00H, writing does nothing.
// RL4: The five pointers are real registers, readable and writable normally.
// RL5: Extended addresses carry the sector in the upper bits, 1F0H is sector 1.
// RL6: No register-to-register move; data goes through the working register.
// RL7: Writing the low program counter jumps within the page, with a dummy cycle.
// RL8: Table read fetches at the pointer pair, high byte kept, low byte stored.
// RL9: Writes to the flag register leave the watchdog and sleep flags alone.
// RL10: Watchdog flag clears on reset, kick or halt; sets on timeout.
// RL11: Sleep flag clears on reset or kick; sets on halt.
// RL12: Carry follows add carry, subtract no-borrow and rotate through carry.
// RL13: Nibble carry follows low nibble carry or no nibble borrow.
// RL14: Zero flag set when the result is zero, cleared otherwise.
// RL15: Overflow set when carry into and out of top bit differ.
// RL16: Sign flag is overflow xor the result's top bit.
// RL17: Chained zero copies zero on subtract, ands with zero on borrow-subtract.
// RL18: Flags are never saved automatically on interrupt or call.
`timescale 1ns/1ps
`include "csr_consts.svh"
module csr_core #(
  parameter int SECTORS = 6,
  parameter int SW = 3
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Data access from the instruction stream
  input wire logic acc_req,
  input wire logic acc_we,
  input wire logic [SW+7:0] acc_addr,
  input wire csr_pkg::csr_byte_t acc_wdata,
  output csr_pkg::csr_byte_t acc_rdata,
  output logic acc_rvalid,
  // ALU flag results
  input wire logic alu_upd,
  input wire csr_pkg::csr_alu_kind_e alu_kind,
  input wire csr_pkg::csr_byte_t alu_result,
  input wire logic alu_cout,
  input wire logic alu_cmsb,
  input wire logic alu_hc,
  input wire logic rot_carry,
  // System events
  input wire logic wdt_expire,
  input wire logic kick_op,
  input wire logic halt_op,
  // Program counter
  input wire csr_pkg::csr_byte_t pc_low_now,
  output logic pc_load,
  output csr_pkg::csr_byte_t pc_load_low,
  output logic dummy_cycle,
  // Table read
  input wire logic tbl_req,
  input wire logic [SW+7:0] tbl_dest,
  output logic prog_req,
  output logic [15:0] prog_addr,
  input wire logic [15:0] prog_data,
  // State view
  output csr_pkg::csr_byte_t flags_out
);
  import csr_pkg::*;

  localparam int AW = SW + 8;
  localparam int DEPTH = SECTORS * `CSR_SECTOR_BYTES;

  // Sector field must hold every sector
  if (SECTORS < 1 || SECTORS > (1 << SW) || SW < 1 || SW > 8) begin : g_bad_cfg
    $error("csr_core: SECTORS does not fit SW");
  end

  csr_byte_t mem [DEPTH];
  csr_byte_t pointer_zero;
  csr_byte_t pointer_one_low;
  csr_byte_t pointer_one_sector;
  csr_byte_t pointer_two_low;
  csr_byte_t pointer_two_sector;
  csr_byte_t table_ptr_low;
  csr_byte_t table_ptr_high;
  csr_byte_t table_data_high;
  csr_byte_t flags;
  csr_seq_e seq;
  csr_seq_e next_seq;
  logic [AW-1:0] dest_q;
  logic acc_take;
  logic pcl_wr;
  logic wr_en;
  logic [AW-1:0] wr_tgt;
  csr_byte_t wr_data;
  logic [AW-1:0] rd_tgt;
  csr_byte_t rd_val;

  // ****************************************
  // Address resolution
  // ****************************************
  // RL1 port redirects to its pointer
  function automatic logic [AW-1:0] resolve(input logic [AW-1:0] a);
    logic [AW-1:0] r;
    r = a;
    case (a[7:0])
      // RL2 port zero stays in sector zero
      `CSR_ADR_PORT0: r = {{SW{1'b0}}, pointer_zero};
      // RL2 sector from paired pointer
      `CSR_ADR_PORT1: r = {pointer_one_sector[SW-1:0], pointer_one_low};
      `CSR_ADR_PORT2: r = {pointer_two_sector[SW-1:0], pointer_two_low};
      default: r = a;
    endcase
    return r;
  endfunction

  // Special offsets repeat in every sector, so only the low byte decides
  function automatic logic is_special(input logic [7:0] o);
    logic s;
    s = 1'b0;
    case (o)
      `CSR_ADR_PORT0, `CSR_ADR_PTR0, `CSR_ADR_PORT1, `CSR_ADR_PTR1L, `CSR_ADR_PTR1S,
      `CSR_ADR_PCLOW, `CSR_ADR_TBLO, `CSR_ADR_TBDH, `CSR_ADR_TBHI, `CSR_ADR_FLAGS,
      `CSR_ADR_PORT2, `CSR_ADR_PTR2L, `CSR_ADR_PTR2S: s = 1'b1;
      default: s = 1'b0;
    endcase
    return s;
  endfunction

  // ****************************************
  // Access steering
  // ****************************************
  // RL6 one address per access, so moves pass the working register
  assign acc_take = acc_req && (seq == csr_seq_idle);
  assign pcl_wr = wr_en && (wr_tgt[7:0] == `CSR_ADR_PCLOW) && (seq == csr_seq_idle);
  // A continuous assign would miss pointer updates that are read inside the function
  always_comb begin
    rd_tgt = resolve(acc_addr);
  end

  always_comb begin
    if (seq == csr_seq_fetch) begin
      // RL8 low byte to chosen location
      wr_en = 1'b1;
      wr_tgt = resolve(dest_q);
      wr_data = prog_data[7:0];
    end else begin
      wr_en = acc_take && acc_we;
      wr_tgt = rd_tgt;
      wr_data = acc_wdata;
    end
  end

  always_comb begin
    case (rd_tgt[7:0])
      // RL3 port location reads as zero
      `CSR_ADR_PORT0, `CSR_ADR_PORT1, `CSR_ADR_PORT2: rd_val = `CSR_PORT_READ;
      `CSR_ADR_PTR0: rd_val = pointer_zero;
      `CSR_ADR_PTR1L: rd_val = pointer_one_low;
      `CSR_ADR_PTR1S: rd_val = pointer_one_sector;
      `CSR_ADR_PTR2L: rd_val = pointer_two_low;
      `CSR_ADR_PTR2S: rd_val = pointer_two_sector;
      `CSR_ADR_PCLOW: rd_val = pc_low_now;
      `CSR_ADR_TBLO: rd_val = table_ptr_low;
      `CSR_ADR_TBDH: rd_val = table_data_high;
      `CSR_ADR_TBHI: rd_val = table_ptr_high;
      `CSR_ADR_FLAGS: rd_val = flags;
      default: rd_val = (int'(rd_tgt) < DEPTH) ? mem[rd_tgt] : `CSR_BYTE_RST;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      acc_rvalid <= 1'b0;
      acc_rdata <= `CSR_BYTE_RST;
    end else begin
      acc_rvalid <= acc_take && !acc_we;
      acc_rdata <= rd_val;
    end
  end

  // ****************************************
  // Data memory
  // ****************************************
  // RL5 sector and offset index the array directly
  always_ff @(posedge ref_clk) begin
    if (wr_en && !is_special(wr_tgt[7:0]) && int'(wr_tgt) < DEPTH) begin
      mem[wr_tgt] <= wr_data;
    end
  end

  // ****************************************
  // Memory pointers
  // ****************************************
  // Pointer sectors reset to zero, keeping ports 1 and 2 in sector 0 after power-up
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pointer_zero <= `CSR_BYTE_RST;
      pointer_one_low <= `CSR_BYTE_RST;
      pointer_one_sector <= `CSR_BYTE_RST;
      pointer_two_low <= `CSR_BYTE_RST;
      pointer_two_sector <= `CSR_BYTE_RST;
    end else if (wr_en) begin
      // RL4 pointers as plain registers
      case (wr_tgt[7:0])
        `CSR_ADR_PTR0: pointer_zero <= wr_data;
        `CSR_ADR_PTR1L: pointer_one_low <= wr_data;
        `CSR_ADR_PTR1S: pointer_one_sector <= wr_data;
        `CSR_ADR_PTR2L: pointer_two_low <= wr_data;
        `CSR_ADR_PTR2S: pointer_two_sector <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Table pointers and table data
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      table_ptr_low <= `CSR_BYTE_RST;
      table_ptr_high <= `CSR_BYTE_RST;
    end else if (wr_en && wr_tgt[7:0] == `CSR_ADR_TBLO) begin
      table_ptr_low <= wr_data;
    end else if (wr_en && wr_tgt[7:0] == `CSR_ADR_TBHI) begin
      table_ptr_high <= wr_data;
    end
  end

  // Table data high is filled only by a table read
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      table_data_high <= `CSR_BYTE_RST;
    end else if (seq == csr_seq_fetch) begin
      // RL8 high byte kept
      table_data_high <= prog_data[15:8];
    end
  end

  // ****************************************
  // Sequencer for jumps and table reads
  // ****************************************
  always_comb begin
    case (seq)
      csr_seq_idle: begin
        if (pcl_wr) begin
          next_seq = csr_seq_dummy;
        end else if (tbl_req) begin
          next_seq = csr_seq_fetch;
        end else begin
          next_seq = csr_seq_idle;
        end
      end
      csr_seq_fetch: next_seq = csr_seq_idle;
      csr_seq_dummy: next_seq = csr_seq_idle;
      default: next_seq = csr_seq_idle;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      seq <= csr_seq_idle;
      dest_q <= '0;
    end else begin
      seq <= next_seq;
      if (seq == csr_seq_idle && !pcl_wr && tbl_req) begin
        dest_q <= tbl_dest;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pc_load <= 1'b0;
      pc_load_low <= `CSR_BYTE_RST;
      dummy_cycle <= 1'b0;
    end else begin
      // RL7 page-local jump and dummy cycle
      pc_load <= pcl_wr;
      dummy_cycle <= (next_seq == csr_seq_dummy);
      if (pcl_wr) begin
        pc_load_low <= wr_data;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prog_req <= 1'b0;
      prog_addr <= {2{`CSR_BYTE_RST}};
    end else begin
      // RL8 fetch at pointer pair
      prog_req <= (next_seq == csr_seq_fetch);
      if (next_seq == csr_seq_fetch) begin
        prog_addr <= {table_ptr_high, table_ptr_low};
      end
    end
  end

  // ****************************************
  // Flag register
  // ****************************************
  // RL18 no stack path exists for the flags
  csr_flag_unit u_flags (
    .ref_clk(ref_clk),
    .reset(reset),
    .alu_upd(alu_upd),
    .alu_kind(alu_kind),
    .alu_result(alu_result),
    .alu_cout(alu_cout),
    .alu_cmsb(alu_cmsb),
    .alu_hc(alu_hc),
    .rot_carry(rot_carry),
    .sw_we(wr_en && wr_tgt[7:0] == `CSR_ADR_FLAGS),
    .sw_data(wr_data),
    .wdt_expire(wdt_expire),
    .kick_op(kick_op),
    .halt_op(halt_op),
    .flags(flags)
  );
  assign flags_out = flags;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  chk_port_reads_zero: assert property ( // RL3
    acc_take && !acc_we && (rd_tgt[7:0] == `CSR_ADR_PORT0 || rd_tgt[7:0] == `CSR_ADR_PORT1)
    |=> acc_rvalid && acc_rdata == `CSR_PORT_READ)
    else $error("port location did not read as zero");
  chk_port_write_lands: assert property ( // RL1
    acc_take && acc_we && acc_addr[7:0] == `CSR_ADR_PORT1 && !is_special(rd_tgt[7:0])
    && int'(rd_tgt) < DEPTH |=> mem[$past(rd_tgt)] == $past(acc_wdata))
    else $error("indirect write missed pointed location");
  chk_port0_sector: assert property ( // RL2
    acc_addr[7:0] == `CSR_ADR_PORT0 |-> rd_tgt[AW-1:8] == '0)
    else $error("port zero left sector zero");
  chk_ext_addr: assert property ( // RL5
    acc_take && acc_we && !is_special(acc_addr[7:0]) && int'(acc_addr) < DEPTH
    |=> mem[{$past(acc_addr[AW-1:8]), $past(acc_addr[7:0])}] == $past(acc_wdata))
    else $error("extended direct write misplaced");
  chk_ptr_write: assert property ( // RL4
    acc_take && acc_we && acc_addr[7:0] == `CSR_ADR_PTR0 |=> pointer_zero == $past(acc_wdata))
    else $error("pointer zero not written");
  chk_jump_dummy: assert property ( // RL7
    pcl_wr |=> pc_load && dummy_cycle && pc_load_low == $past(wr_data) && !acc_take ##1 !dummy_cycle)
    else $error("jump or dummy cycle wrong");
  chk_table_read: assert property ( // RL8
    seq == csr_seq_idle && !pcl_wr && tbl_req
    |=> prog_req && prog_addr == {table_ptr_high, table_ptr_low}
    ##1 !prog_req && table_data_high == $past(prog_data[15:8]))
    else $error("table read sequence wrong");
  chk_flag_protect: assert property ( // RL9
    wr_en && wr_tgt[7:0] == `CSR_ADR_FLAGS && !wdt_expire && !kick_op && !halt_op
    |=> $stable(flags_out[`CSR_BIT_WDOG]) && $stable(flags_out[`CSR_BIT_SLEEP]))
    else $error("write changed system flags");
  chk_wdog_set: assert property ( // RL10
    wdt_expire |=> flags_out[`CSR_BIT_WDOG])
    else $error("timeout flag not set");
  chk_halt_flags: assert property ( // RL11
    halt_op && !wdt_expire |=> flags_out[`CSR_BIT_SLEEP] && !flags_out[`CSR_BIT_WDOG])
    else $error("halt flags wrong");
  chk_carry_add: assert property ( // RL12
    alu_upd && alu_kind == csr_alu_add |=> flags_out[`CSR_BIT_C] == $past(alu_cout))
    else $error("carry flag wrong");
  chk_nibble: assert property ( // RL13
    alu_upd && alu_kind == csr_alu_sub |=> flags_out[`CSR_BIT_HC] == $past(alu_hc))
    else $error("nibble carry wrong");
  chk_zero_flag: assert property ( // RL14
    alu_upd && alu_kind == csr_alu_logic |=> flags_out[`CSR_BIT_Z] == ($past(alu_result) == 8'h00))
    else $error("zero flag wrong");
  chk_overflow: assert property ( // RL15
    alu_upd && alu_kind == csr_alu_add |=> flags_out[`CSR_BIT_OV] == $past(alu_cmsb ^ alu_cout))
    else $error("overflow flag wrong");
  chk_sign_xor: assert property ( // RL16
    alu_upd && alu_kind == csr_alu_sbc
    |=> flags_out[`CSR_BIT_SIGN] == (flags_out[`CSR_BIT_OV] ^ $past(alu_result[7])))
    else $error("sign flag wrong");
  chk_chain_sbc: assert property ( // RL17
    alu_upd && alu_kind == csr_alu_sbc
    |=> flags_out[`CSR_BIT_CHAIN] == ($past(flags_out[`CSR_BIT_CHAIN]) && $past(alu_result) == 8'h00))
    else $error("chained zero wrong");

  cov_indirect_sector: cover property (acc_take && acc_addr[7:0] == `CSR_ADR_PORT2 && rd_tgt[AW-1:8] != '0);
  cov_jump: cover property (pcl_wr ##1 dummy_cycle);
  cov_table: cover property (prog_req ##1 table_data_high != `CSR_BYTE_RST);
  cov_halt_kick: cover property (halt_op ##[1:20] kick_op);
endmodule

// >>> sim/tb_cpu_special_registers.sv
// Self-checking bench of the special-register block: data access, jump, table read, flags.
// Assumes csr_consts.svh, csr_pkg and hdl/csr_core.sv are compiled before this file.
`timescale 1ns/1ps
module tb_cpu_special_registers;
  import csr_pkg::*;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic ref_clk = 1'h0;
  logic reset = 1'h1;
  logic acc_req = 1'h0;
  logic acc_we = 1'h0;
  logic [10:0] acc_addr = 11'h000;
  csr_byte_t acc_wdata = 8'h00;
  csr_byte_t acc_rdata;
  logic acc_rvalid;
  logic alu_upd = 1'h0;
  csr_alu_kind_e alu_kind = csr_alu_none;
  csr_byte_t alu_result = 8'h00;
  logic [3:0] alu_bits = 4'h0;
  logic wdt_expire = 1'h0;
  logic kick_op = 1'h0;
  logic halt_op = 1'h0;
  csr_byte_t pc_low_now = 8'h5c;
  csr_byte_t pc_load_low;
  logic pc_load;
  logic dummy_cycle;
  logic tbl_req = 1'h0;
  logic [10:0] tbl_dest = 11'h000;
  logic prog_req;
  logic [15:0] prog_addr;
  logic [15:0] prog_data = 16'h0000;
  csr_byte_t flags_out;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;

  always #10 ref_clk = ~ref_clk;

  csr_core #(.SECTORS(6), .SW(3)) uut (
    .ref_clk(ref_clk), .reset(reset),
    .acc_req(acc_req), .acc_we(acc_we), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
    .alu_upd(alu_upd), .alu_kind(alu_kind), .alu_result(alu_result), .alu_cout(alu_bits[3]),
    .alu_cmsb(alu_bits[2]), .alu_hc(alu_bits[1]), .rot_carry(alu_bits[0]),
    .wdt_expire(wdt_expire), .kick_op(kick_op), .halt_op(halt_op),
    .pc_low_now(pc_low_now), .pc_load(pc_load), .pc_load_low(pc_load_low), .dummy_cycle(dummy_cycle),
    .tbl_req(tbl_req), .tbl_dest(tbl_dest), .prog_req(prog_req), .prog_addr(prog_addr),
    .prog_data(prog_data), .flags_out(flags_out)
  );

  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic close_out;
    $display("Checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One access, held for the single cycle in which the idle block takes it
  task automatic acc(input logic we, input logic [10:0] a, input csr_byte_t d);
    @(posedge ref_clk);
    acc_req <= 1'h1;
    acc_we <= we;
    acc_addr <= a;
    acc_wdata <= d;
    @(posedge ref_clk);
    acc_req <= 1'h0;
    #1;
  endtask

  task automatic rd(input logic [10:0] a, input csr_byte_t exp);
    acc(1'h0, a, 8'h00);
    chk({15'h0000, acc_rvalid}, 16'h0001);
    chk({8'h00, acc_rdata}, {8'h00, exp});
  endtask

  // Events are {wdt, kick, halt, alu}; alu bits are {cout, cmsb, hc, rot}
  task automatic ev(input logic [3:0] e, input logic [2:0] k, input csr_byte_t r, input logic [3:0] b,
                    input csr_byte_t exp);
    @(posedge ref_clk);
    {wdt_expire, kick_op, halt_op, alu_upd} <= e;
    alu_kind <= csr_alu_kind_e'(k);
    alu_result <= r;
    alu_bits <= b;
    @(posedge ref_clk);
    {wdt_expire, kick_op, halt_op, alu_upd} <= 4'h0;
    #1;
    chk({8'h00, flags_out}, {8'h00, exp});
  endtask

  // A hang ends the run through the same report
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      $display("Run stopped at cycle limit");
      close_out();
    end
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'h0;
    #1;
    chk({8'h00, flags_out}, 16'h0000);
    acc(1'h1, 11'h001, 8'h40);
    rd(11'h001, 8'h40);
    acc(1'h1, 11'h000, 8'h5a);
    rd(11'h040, 8'h5a);
    rd(11'h000, 8'h5a);
    acc(1'h1, 11'h004, 8'h01);
    acc(1'h1, 11'h003, 8'hf0);
    acc(1'h1, 11'h002, 8'ha5);
    rd(11'h1f0, 8'ha5);
    acc(1'h1, 11'h00e, 8'h01);
    acc(1'h1, 11'h00d, 8'hf0);
    rd(11'h00c, 8'ha5);
    acc(1'h1, 11'h2f0, 8'hc3);
    acc(1'h1, 11'h00e, 8'h02);
    rd(11'h00c, 8'hc3);
    rd(11'h2f0, 8'hc3);
    acc(1'h1, 11'h00e, 8'h01);
    acc(1'h1, 11'h001, 8'h02);
    rd(11'h000, 8'h00);
    acc(1'h1, 11'h000, 8'h77);
    rd(11'h003, 8'hf0);
    rd(11'h1f0, 8'ha5);
    rd(11'h006, 8'h5c);
    acc(1'h1, 11'h006, 8'h33);
    chk({14'h0000, pc_load, dummy_cycle}, 16'h0003);
    chk({8'h00, pc_load_low}, 16'h0033);
    @(posedge ref_clk);
    #1;
    chk({14'h0000, pc_load, dummy_cycle}, 16'h0000);
    acc(1'h1, 11'h007, 8'h12);
    acc(1'h1, 11'h009, 8'h34);
    @(posedge ref_clk);
    tbl_req <= 1'h1;
    tbl_dest <= 11'h041;
    @(posedge ref_clk);
    tbl_req <= 1'h0;
    prog_data <= 16'hbeef;
    #1;
    chk({15'h0000, prog_req}, 16'h0001);
    chk(prog_addr, 16'h3412);
    @(posedge ref_clk);
    prog_data <= 16'h4110;
    rd(11'h008, 8'hbe);
    rd(11'h041, 8'hef);
    acc(1'h1, 11'h008, 8'h77);
    rd(11'h008, 8'hbe);
    ev(4'h2, 3'h0, 8'h00, 4'h0, 8'h10);
    ev(4'h8, 3'h0, 8'h00, 4'h0, 8'h30);
    acc(1'h1, 11'h00a, 8'hff);
    chk({8'h00, flags_out}, 16'h003f);
    ev(4'h4, 3'h0, 8'h00, 4'h0, 8'h0f);
    ev(4'h1, 3'h1, 8'h00, 4'ha, 8'h8f);
    ev(4'h1, 3'h2, 8'h00, 4'hc, 8'h45);
    ev(4'h1, 3'h3, 8'h80, 4'h6, 8'h0a);
    ev(4'h1, 3'h3, 8'h00, 4'h0, 8'h04);
    ev(4'h1, 3'h4, 8'h01, 4'h0, 8'h00);
    ev(4'h1, 3'h5, 8'h00, 4'h1, 8'h01);
    ev(4'h1, 3'h0, 8'h00, 4'h0, 8'h01);
    ev(4'ha, 3'h0, 8'h00, 4'h0, 8'h31);
    ev(4'h2, 3'h0, 8'h00, 4'h0, 8'h11);
    ev(4'h4, 3'h0, 8'h00, 4'h0, 8'h01);
    close_out();
  end
endmodule
